// [rtl/acp_pkg.sv]
// Shared constants and types of the converter control port and its host
package acp_pkg;
  // Timing in printed units and derived cycle counts at 100 MHz
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CONV_TIME_NS = 6000;
  localparam int unsigned NAP_WAKE_NS = 620;
  localparam int unsigned REF_WAKE_MS = 3;
  localparam int unsigned CONV_CYC =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned NAP_WAKE_CYC =
    (NAP_WAKE_NS / CLK_PERIOD_NS < 1) ? 1 : NAP_WAKE_NS / CLK_PERIOD_NS;
  localparam int unsigned REF_WAKE_CYC =
    REF_WAKE_MS * 1000000 / CLK_PERIOD_NS;

  // Widths
  localparam int unsigned RES_W = 12;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned CMP_CNT_W = 10;
  localparam int unsigned REF_CNT_W = 19;
  localparam int unsigned HOST_CNT_W = 20;

  // Host sequencing
  localparam int unsigned PULSE_CYC = 4;
  localparam int unsigned SETTLE_CYC = 8;
  localparam int unsigned TIMEOUT_CYC = 400000;

  // Host register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_START = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_ST = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // Control register layout
  localparam int unsigned CTRL_W = 7;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_TWO_BYTE = 3;
  localparam int unsigned CTRL_SELECT = 4;
  localparam int unsigned CTRL_SLEEP = 5;
  localparam int unsigned CTRL_NAP = 6;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // Status and interrupt layouts
  localparam int unsigned STAT_ACTIVE = 0;
  localparam int unsigned STAT_ADC_BUSY = 1;
  localparam int unsigned STAT_REF_READY = 2;
  localparam int unsigned STAT_TIMEOUT = 3;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_REF = 1;
  localparam int unsigned IRQ_TIMEOUT = 2;

  typedef enum logic [2:0] {
    MODE_LOW_PULSE = 3'h0,
    MODE_HIGH_PULSE = 3'h1,
    MODE_SHARED = 3'h2,
    MODE_SLOW_MEM = 3'h3,
    MODE_ROM = 3'h4
  } acp_mode_t;

  typedef enum logic [1:0] {
    CMP_OFF = 2'h0,
    CMP_WAKE = 2'h1,
    CMP_READY = 2'h2,
    CMP_CONV = 2'h3
  } acp_cmp_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_STRB = 3'h1,
    H_WLOW = 3'h2,
    H_WHIGH = 3'h3,
    H_READ = 3'h4,
    H_DONE = 3'h5
  } acp_host_state_t;
endpackage

// [rtl/acp_if.sv]
// Parallel pin bundle between converter control port and its host
`timescale 1ns/1ps
interface acp_if;
  logic cs_n;
  logic rd_n;
  logic conversion_start_n;
  logic high_byte_select;
  logic sleep_n;
  logic nap_n;
  logic busy_n;
  logic reference_ready;
  logic [11:0] data;
  logic data_oe_n;
  wire [11:0] data_bus;

  // Released lines show the inverse of the last word, so late reads show
  assign data_bus = data_oe_n ? ~data : data;

  modport dev (
    input cs_n, rd_n, conversion_start_n, high_byte_select, sleep_n, nap_n,
    output busy_n, reference_ready, data, data_oe_n
  );
  modport hst (
    output cs_n, rd_n, conversion_start_n, high_byte_select, sleep_n, nap_n,
    input busy_n, reference_ready, data_bus
  );
endinterface

// [rtl/acp_device.sv]
// Converter control port: start, busy, result latch, readout, power-down
`timescale 1ns/1ps
module acp_device #(
  parameter int unsigned WAKE_CYC = acp_pkg::REF_WAKE_CYC
) (
  input wire logic CLOCK_I, // System clock
  input wire logic RESETN_I, // Async reset, active low
  input wire logic [11:0] SAMPLE_I, // Quantised analog input
  input wire logic TWO_BYTE_I, // 1: two-byte readout variant
  output logic CONV_DONE_O, // Pulse when a result is latched
  acp_if.dev LINK // Pins toward the host
);

  // Pin synchronisers
  logic [5:0] pin_meta_q;
  logic [5:0] pin_sync_q;
  logic cs_n_s;
  logic rd_n_s;
  logic cst_n_s;
  logic hbs_s;
  logic sleep_n_s;
  logic nap_n_s;

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pin_meta_q <= 6'h2B;
      pin_sync_q <= 6'h2B;
    end else begin
      pin_meta_q <= {LINK.cs_n, LINK.rd_n, LINK.conversion_start_n,
                     LINK.high_byte_select, LINK.sleep_n, LINK.nap_n};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign {cs_n_s, rd_n_s, cst_n_s, hbs_s, sleep_n_s, nap_n_s} = pin_sync_q;

  // Start-line edge detect
  logic cst_prev_q;
  logic start_fall;

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cst_prev_q <= 1'b1;
    end else begin
      cst_prev_q <= cst_n_s;
    end
  end

  assign start_fall = cst_prev_q && !cst_n_s;

  // Reference wake-up after deep power-down release
  logic [18:0] ref_cnt_q;
  logic [18:0] ref_cnt_d;
  logic ref_rdy_q;
  logic ref_rdy_d;

  always_comb begin
    ref_cnt_d = ref_cnt_q;
    ref_rdy_d = ref_rdy_q;
    if (!sleep_n_s) begin
      ref_cnt_d = 19'h0_0000;
      ref_rdy_d = 1'b0;
    end else if (!ref_rdy_q) begin
      if (ref_cnt_q == 19'(WAKE_CYC - 1)) begin
        ref_rdy_d = 1'b1;
      end else begin
        ref_cnt_d = ref_cnt_q + 19'h0_0001;
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ref_cnt_q <= 19'h0_0000;
      ref_rdy_q <= 1'b0;
    end else begin
      ref_cnt_q <= ref_cnt_d;
      ref_rdy_q <= ref_rdy_d;
    end
  end

  // Comparator power and conversion sequencing
  acp_pkg::acp_cmp_state_t cmp_q;
  acp_pkg::acp_cmp_state_t cmp_d;
  logic [9:0] cmp_cnt_q;
  logic [9:0] cmp_cnt_d;
  logic [11:0] hold_q;
  logic [11:0] hold_d;
  logic [11:0] result_q;
  logic [11:0] result_d;
  logic done_q;
  logic done_d;
  logic cmp_power;

  // Comparator runs only with both power-down lines released
  assign cmp_power = sleep_n_s && nap_n_s;

  always_comb begin
    cmp_d = cmp_q;
    cmp_cnt_d = cmp_cnt_q;
    hold_d = hold_q;
    result_d = result_q;
    done_d = 1'b0;
    case (cmp_q)
      acp_pkg::CMP_OFF: begin
        cmp_cnt_d = 10'h000;
        if (cmp_power) begin
          cmp_d = acp_pkg::CMP_WAKE;
        end
      end
      acp_pkg::CMP_WAKE: begin
        if (!cmp_power) begin
          cmp_d = acp_pkg::CMP_OFF;
        end else if (cmp_cnt_q == 10'(acp_pkg::NAP_WAKE_CYC - 1)) begin
          cmp_d = acp_pkg::CMP_READY;
          cmp_cnt_d = 10'h000;
        end else begin
          cmp_cnt_d = cmp_cnt_q + 10'h001;
        end
      end
      acp_pkg::CMP_READY: begin
        cmp_cnt_d = 10'h000;
        if (!cmp_power) begin
          cmp_d = acp_pkg::CMP_OFF;
        end else if (start_fall && !cs_n_s && ref_rdy_q) begin
          cmp_d = acp_pkg::CMP_CONV;
          hold_d = SAMPLE_I;
        end
      end
      acp_pkg::CMP_CONV: begin
        // Start edges are not looked at here
        if (!cmp_power) begin
          cmp_d = acp_pkg::CMP_OFF;
        end else if (cmp_cnt_q == 10'(acp_pkg::CONV_CYC - 1)) begin
          cmp_d = acp_pkg::CMP_READY;
          cmp_cnt_d = 10'h000;
          result_d = hold_q;
          done_d = 1'b1;
        end else begin
          cmp_cnt_d = cmp_cnt_q + 10'h001;
        end
      end
      default: begin
        cmp_d = acp_pkg::CMP_OFF;
        cmp_cnt_d = 10'h000;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cmp_q <= acp_pkg::CMP_OFF;
      cmp_cnt_q <= 10'h000;
      hold_q <= 12'h000;
      result_q <= 12'h000;
      done_q <= 1'b0;
    end else begin
      cmp_q <= cmp_d;
      cmp_cnt_q <= cmp_cnt_d;
      hold_q <= hold_d;
      result_q <= result_d;
      done_q <= done_d;
    end
  end

  // Pin outputs; data and busy move on the same edge
  logic busy_n_q;
  logic busy_n_d;
  logic [11:0] data_q;
  logic [11:0] data_d;
  logic oe_n_q;
  logic oe_n_d;

  always_comb begin
    busy_n_d = (cmp_d != acp_pkg::CMP_CONV);
    oe_n_d = !(!cs_n_s && !rd_n_s);
    if (TWO_BYTE_I) begin
      if (hbs_s) begin
        data_d = {8'h00, result_d[11:8]};
      end else begin
        data_d = {4'h0, result_d[7:0]};
      end
    end else begin
      data_d = result_d;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      busy_n_q <= 1'b1;
      data_q <= 12'h000;
      oe_n_q <= 1'b1;
    end else begin
      busy_n_q <= busy_n_d;
      data_q <= data_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign LINK.busy_n = busy_n_q;
  assign LINK.data = data_q;
  assign LINK.data_oe_n = oe_n_q;
  assign LINK.reference_ready = ref_rdy_q;
  assign CONV_DONE_O = done_q;

endmodule

// [rtl/acp_host.sv]
// Host end: AHB-Lite registers driving the converter pins in five modes
`timescale 1ns/1ps
module acp_host #(
  parameter int unsigned TIMEOUT = acp_pkg::TIMEOUT_CYC
) (
  input wire logic CLOCK_I, // System clock
  input wire logic RESETN_I, // Async reset, active low
  input wire logic HSEL_I, // AHB slave select
  input wire logic [31:0] HADDR_I, // AHB address
  input wire logic [1:0] HTRANS_I, // AHB transfer type
  input wire logic HWRITE_I, // AHB write
  input wire logic [2:0] HSIZE_I, // AHB size, word only
  input wire logic [31:0] HWDATA_I, // AHB write data
  input wire logic HREADY_I, // AHB bus ready
  output logic HREADYOUT_O, // AHB slave ready
  output logic HRESP_O, // AHB response, always OKAY
  output logic [31:0] HRDATA_O, // AHB read data
  output logic IRQ_O, // Level interrupt
  acp_if.hst LINK // Pins toward the converter
);

  // Pin synchronisers
  logic [13:0] in_meta_q;
  logic [13:0] in_sync_q;
  logic busy_n_s;
  logic ref_s;
  logic [11:0] data_s;

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      in_meta_q <= 14'h2000;
      in_sync_q <= 14'h2000;
    end else begin
      in_meta_q <= {LINK.busy_n, LINK.reference_ready, LINK.data_bus};
      in_sync_q <= in_meta_q;
    end
  end

  assign {busy_n_s, ref_s, data_s} = in_sync_q;

  // Bus slave and registers
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic [6:0] ctrl_q;
  logic [2:0] irq_st_q;
  logic [2:0] irq_mask_q;
  logic timeout_q;
  logic ref_prev_q;
  logic [11:0] result_q;
  logic [11:0] result_d;
  logic addr_ok;
  logic rd_irq;
  logic go;
  logic done_ev;
  logic to_ev;
  logic [2:0] irq_ev;
  logic [31:0] rdata_d;
  acp_pkg::acp_host_state_t st_q;
  acp_pkg::acp_host_state_t st_d;
  acp_pkg::acp_mode_t mode;

  assign addr_ok = HSEL_I && HTRANS_I[1] && HREADY_I;
  assign rd_irq = addr_ok && !HWRITE_I &&
                  (HADDR_I[7:0] == acp_pkg::OFS_IRQ_ST);
  assign go = wr_pend_q && (wr_addr_q == acp_pkg::OFS_START) &&
              (st_q == acp_pkg::H_IDLE);
  assign irq_ev = {to_ev, ref_s && !ref_prev_q, done_ev};
  assign mode = acp_pkg::acp_mode_t'(ctrl_q[2:0]);

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (HADDR_I[7:0])
      acp_pkg::OFS_CTRL: rdata_d = {25'h000_0000, ctrl_q};
      acp_pkg::OFS_STATUS: rdata_d = {28'h000_0000, timeout_q, ref_s,
                                      !busy_n_s, st_q != acp_pkg::H_IDLE};
      acp_pkg::OFS_RESULT: rdata_d = {20'h0_0000, result_q};
      acp_pkg::OFS_IRQ_ST: rdata_d = {29'h000_0000, irq_st_q};
      acp_pkg::OFS_IRQ_MASK: rdata_d = {29'h000_0000, irq_mask_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
      ctrl_q <= acp_pkg::CTRL_RESET;
      irq_st_q <= 3'h0;
      irq_mask_q <= 3'h0;
      timeout_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end else begin
      wr_pend_q <= addr_ok && HWRITE_I;
      wr_addr_q <= HADDR_I[7:0];
      if (addr_ok && !HWRITE_I) begin
        rdata_q <= rdata_d;
      end
      if (wr_pend_q && wr_addr_q == acp_pkg::OFS_CTRL) begin
        ctrl_q <= HWDATA_I[6:0];
      end
      if (wr_pend_q && wr_addr_q == acp_pkg::OFS_IRQ_MASK) begin
        irq_mask_q <= HWDATA_I[2:0];
      end
      // Set wins over the read clear
      irq_st_q <= (irq_st_q & ~{3{rd_irq}}) | irq_ev;
      timeout_q <= to_ev || (timeout_q && !go);
      ref_prev_q <= ref_s;
    end
  end

  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign HRDATA_O = rdata_q;
  assign IRQ_O = |(irq_st_q & irq_mask_q);

  // Pin sequencer
  logic [19:0] cnt_q;
  logic [19:0] cnt_d;
  logic cst_q;
  logic cst_d;
  logic strobe_q;
  logic strobe_d;
  logic hbs_q;
  logic hbs_d;
  logic rom_q;
  logic rom_d;
  logic [7:0] lo_q;
  logic [7:0] lo_d;
  logic idle_lvl;
  logic tied;
  logic two;

  assign idle_lvl = (mode != acp_pkg::MODE_HIGH_PULSE);
  assign tied = (mode == acp_pkg::MODE_SLOW_MEM) ||
                (mode == acp_pkg::MODE_ROM);
  assign two = ctrl_q[acp_pkg::CTRL_TWO_BYTE];

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 20'h0_0001;
    cst_d = cst_q;
    strobe_d = strobe_q;
    hbs_d = hbs_q;
    rom_d = rom_q;
    lo_d = lo_q;
    result_d = result_q;
    done_ev = 1'b0;
    to_ev = 1'b0;
    case (st_q)
      acp_pkg::H_IDLE: begin
        cst_d = idle_lvl;
        strobe_d = 1'b0;
        hbs_d = 1'b0;
        cnt_d = 20'h0_0000;
        if (go) begin
          st_d = acp_pkg::H_STRB;
          cst_d = !idle_lvl;
          rom_d = 1'b0;
        end
      end
      acp_pkg::H_STRB: begin
        if (mode == acp_pkg::MODE_ROM) begin
          st_d = acp_pkg::H_READ;
          cnt_d = 20'h0_0000;
        end else if (tied) begin
          st_d = acp_pkg::H_WLOW;
          cnt_d = 20'h0_0000;
        end else if (cnt_q == 20'(acp_pkg::PULSE_CYC - 1)) begin
          cst_d = idle_lvl;
          st_d = acp_pkg::H_WLOW;
          cnt_d = 20'h0_0000;
        end
      end
      acp_pkg::H_WLOW, acp_pkg::H_WHIGH: begin
        if ((st_q == acp_pkg::H_WLOW) && !busy_n_s) begin
          st_d = acp_pkg::H_WHIGH;
          cnt_d = 20'h0_0000;
        end else if ((st_q == acp_pkg::H_WHIGH) && busy_n_s) begin
          st_d = rom_q ? acp_pkg::H_DONE : acp_pkg::H_READ;
          cnt_d = 20'h0_0000;
        end else if (cnt_q == 20'(TIMEOUT - 1)) begin
          to_ev = 1'b1;
          st_d = acp_pkg::H_DONE;
        end
      end
      acp_pkg::H_READ: begin
        strobe_d = 1'b1;
        if (cnt_q == 20'(acp_pkg::SETTLE_CYC - 1)) begin
          cnt_d = 20'h0_0000;
          if (two && !hbs_q) begin
            lo_d = data_s[7:0];
            hbs_d = 1'b1;
          end else begin
            result_d = two ? {data_s[3:0], lo_q} : data_s;
            strobe_d = 1'b0;
            hbs_d = 1'b0;
            if (mode == acp_pkg::MODE_ROM && !rom_q) begin
              rom_d = 1'b1;
              cst_d = 1'b1;
              st_d = acp_pkg::H_WLOW;
            end else begin
              st_d = acp_pkg::H_DONE;
            end
          end
        end
      end
      acp_pkg::H_DONE: begin
        cst_d = idle_lvl;
        strobe_d = 1'b0;
        hbs_d = 1'b0;
        done_ev = !timeout_q && !to_ev;
        st_d = acp_pkg::H_IDLE;
      end
      default: begin
        st_d = acp_pkg::H_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_q <= acp_pkg::H_IDLE;
      cnt_q <= 20'h0_0000;
      cst_q <= 1'b1;
      strobe_q <= 1'b0;
      hbs_q <= 1'b0;
      rom_q <= 1'b0;
      lo_q <= 8'h00;
      result_q <= 12'h000;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      cst_q <= cst_d;
      strobe_q <= strobe_d;
      hbs_q <= hbs_d;
      rom_q <= rom_d;
      lo_q <= lo_d;
      result_q <= result_d;
    end
  end

  // Read line: tied low, strobed, or joined to the start line
  assign LINK.rd_n = tied ? cst_q :
                     (mode == acp_pkg::MODE_SHARED) ? !strobe_q : 1'b0;
  assign LINK.conversion_start_n = cst_q;
  assign LINK.high_byte_select = hbs_q;
  assign LINK.cs_n = !ctrl_q[acp_pkg::CTRL_SELECT];
  assign LINK.sleep_n = !ctrl_q[acp_pkg::CTRL_SLEEP];
  assign LINK.nap_n = !ctrl_q[acp_pkg::CTRL_NAP];

endmodule

// [testbench/acp_checker.sv]
// Pin-level assertions between the converter port and its host
`timescale 1ns/1ps
module acp_checker #(
  parameter int unsigned WAKE_CYC = acp_pkg::REF_WAKE_CYC
) (
  input wire logic CLOCK_I, // Clock
  input wire logic RESETN_I, // Reset, active low
  input wire logic cs_n, // Select
  input wire logic rd_n, // Read strobe
  input wire logic conversion_start_n, // Start line
  input wire logic high_byte_select, // Byte select
  input wire logic sleep_n, // Deep power-down
  input wire logic nap_n, // Light power-down
  input wire logic busy_n, // Conversion running
  input wire logic reference_ready, // Reference awake
  input wire logic [11:0] data, // Device data
  input wire logic data_oe_n // Data enable, active low
);
  logic [9:0] busy_cnt_q;
  logic [9:0] busy_cnt_d;
  logic [19:0] ref_cnt_q;
  logic [19:0] ref_cnt_d;

  // Busy low length and time since sleep release
  always_comb begin
    busy_cnt_d = busy_n ? 10'h000 : busy_cnt_q + 10'h001;
    ref_cnt_d = ref_cnt_q + {19'h0_0000, ~&ref_cnt_q};
    if (!sleep_n) begin
      ref_cnt_d = 20'h0_0000;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      busy_cnt_q <= 10'h000;
      ref_cnt_q <= 20'h0_0000;
    end else begin
      busy_cnt_q <= busy_cnt_d;
      ref_cnt_q <= ref_cnt_d;
    end
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);

  chk_start_cause: assert property (
    $fell(busy_n) |-> !$past(conversion_start_n, 2) && !$past(cs_n, 2)
      && $past(sleep_n, 2) && $past(nap_n, 2) && $past(reference_ready))
    else $error("conversion began without a selected start");
  chk_no_restart: assert property (
    !busy_n |-> busy_cnt_q < acp_pkg::CONV_CYC)
    else $error("busy stayed low too long");
  chk_busy_length: assert property (
    $rose(busy_n) && sleep_n && nap_n |-> busy_cnt_q == acp_pkg::CONV_CYC)
    else $error("busy low time wrong");
  chk_latch_hold: assert property (
    !busy_n && $past(!busy_n) && $stable(high_byte_select)
      && $past(high_byte_select, 2) == high_byte_select
      && $past(high_byte_select, 3) == high_byte_select
      && $past(high_byte_select, 4) == high_byte_select |-> $stable(data))
    else $error("data changed during conversion");
  chk_oe_follow: assert property (
    data_oe_n == !$past(!cs_n && !rd_n, 3))
    else $error("data enable does not follow select and read");
  chk_ref_wake: assert property (
    $rose(reference_ready) |-> ref_cnt_q >= WAKE_CYC)
    else $error("reference ready rose too early");
  chk_sleep_block: assert property (
    !sleep_n [*4] |-> busy_n)
    else $error("conversion while in deep power-down");
  chk_nap_block: assert property (
    !nap_n [*4] |-> busy_n)
    else $error("conversion while in light power-down");

  cover property ($fell(busy_n));
  cover property ($fell(data_oe_n) && high_byte_select);
  cover property ($rose(reference_ready));
endmodule

// [testbench/test_adc_conversion_control_port.sv]
// Self-checking bench for the converter port and its host
`timescale 1ns/1ps
module test_adc_conversion_control_port;
  localparam int unsigned WAKE = 100;
  localparam int unsigned TMO = 2000;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic irq;
  logic [11:0] sample = 12'h000;
  logic two_byte = 1'b0;
  logic conv_done;
  logic slow_chk = 1'b0;
  logic [11:0] prev = 12'h000;
  logic [11:0] smp;
  int err_total = 0;
  int samples_checked = 0;
  int done_cnt = 0;
  int n_conv = 0;

  acp_if link();
  acp_device #(.WAKE_CYC(WAKE)) u_acp_device (
    .CLOCK_I(clock_i),
    .RESETN_I(resetn_i),
    .SAMPLE_I(sample),
    .TWO_BYTE_I(two_byte),
    .CONV_DONE_O(conv_done),
    .LINK(link)
  );
  acp_host #(.TIMEOUT(TMO)) u_acp_host (
    .CLOCK_I(clock_i),
    .RESETN_I(resetn_i),
    .HSEL_I(hsel),
    .HADDR_I(haddr),
    .HTRANS_I(htrans),
    .HWRITE_I(hwrite),
    .HSIZE_I(3'b010),
    .HWDATA_I(hwdata),
    .HREADY_I(hreadyout),
    .HREADYOUT_O(hreadyout),
    .HRESP_O(hresp),
    .HRDATA_O(hrdata),
    .IRQ_O(irq),
    .LINK(link)
  );
  acp_checker #(.WAKE_CYC(WAKE)) u_acp_checker (
    .CLOCK_I(clock_i),
    .RESETN_I(resetn_i),
    .cs_n(link.cs_n),
    .rd_n(link.rd_n),
    .conversion_start_n(link.conversion_start_n),
    .high_byte_select(link.high_byte_select),
    .sleep_n(link.sleep_n),
    .nap_n(link.nap_n),
    .busy_n(link.busy_n),
    .reference_ready(link.reference_ready),
    .data(link.data),
    .data_oe_n(link.data_oe_n)
  );

  initial begin
    forever #5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    if (conv_done === 1'b1) done_cnt++;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] adr,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock_i);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, adr};
    hwrite <= wr;
    do @(posedge clock_i); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clock_i); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] unused;
    bus(1'b1, adr, wd, unused);
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, adr, 32'h0000_0000, got);
    check(got, exp);
  endtask

  task automatic wait_bit(input int b, input logic v);
    logic [31:0] s;
    int n;
    n = 0;
    s = 32'h0000_0000;
    do begin
      bus(1'b0, acp_pkg::OFS_STATUS, 32'h0000_0000, s);
      n++;
    end while (s[b] !== v && n < 3000);
    check(s[b], v);
  endtask

  task automatic ctrl(input logic [2:0] m, input logic tb, input logic sel,
                      input logic slp, input logic nap);
    wr(acp_pkg::OFS_CTRL, {25'h000_0000, nap, slp, sel, tb, m});
  endtask

  // Mode set with select off first, so a mode change never starts one
  task automatic conv(input logic [2:0] m, input logic tb,
                      input logic [11:0] s, input logic [11:0] exp);
    sample <= s;
    two_byte <= tb;
    ctrl(m, tb, 1'b0, 1'b0, 1'b0);
    ctrl(m, tb, 1'b1, 1'b0, 1'b0);
    wr(acp_pkg::OFS_START, 32'h0000_0001);
    wait_bit(acp_pkg::STAT_ADC_BUSY, 1'b1);
    wait_bit(acp_pkg::STAT_ACTIVE, 1'b0);
    rdc(acp_pkg::OFS_RESULT, {20'h0_0000, exp});
    check(irq, 1'b1);
    rdc(acp_pkg::OFS_IRQ_ST, 32'h0000_0001);
    check(irq, 1'b0);
    n_conv++;
  endtask

  // Old result on the lines while a slow-memory conversion runs
  always @(negedge link.busy_n) begin
    if (slow_chk) begin
      repeat (4) @(posedge clock_i);
      check(link.data_bus, two_byte ? {4'h0, prev[7:0]} : prev);
    end
  end

  initial begin
    repeat (100000) @(posedge clock_i);
    err_total++;
    $display("mismatch at %0t: run did not finish", $time);
    final_report();
  end

  initial begin
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    wait_bit(acp_pkg::STAT_REF_READY, 1'b1);
    rdc(acp_pkg::OFS_IRQ_ST, 32'h0000_0002);
    rdc(acp_pkg::OFS_IRQ_ST, 32'h0000_0000);
    wr(acp_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    for (int m = 0; m < 4; m++) begin
      for (int t = 0; t < 2; t++) begin
        smp = 12'h5A1 + 12'(m * 311 + t * 97);
        slow_chk <= (m == 3);
        conv(3'(m), t[0], smp, smp);
        slow_chk <= 1'b0;
        prev = smp;
        if (m == 2) check(link.data_oe_n, 1'b1);
        if (m == 0 && t == 0) check(link.data_bus, smp);
      end
    end
    conv(3'h4, 1'b0, 12'h3C6, prev);
    conv(3'h4, 1'b1, 12'h0E9, 12'h3C6);
    prev = 12'h3C6;
    ctrl(3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    wr(acp_pkg::OFS_START, 32'h0000_0001);
    wait_bit(acp_pkg::STAT_ACTIVE, 1'b0);
    rdc(acp_pkg::OFS_STATUS, 32'h0000_000C);
    rdc(acp_pkg::OFS_IRQ_ST, 32'h0000_0004);
    rdc(acp_pkg::OFS_RESULT, {20'h0_0000, prev});
    ctrl(3'h0, 1'b0, 1'b1, 1'b1, 1'b0);
    wr(acp_pkg::OFS_START, 32'h0000_0001);
    wait_bit(acp_pkg::STAT_ACTIVE, 1'b0);
    rdc(acp_pkg::OFS_STATUS, 32'h0000_0008);
    check(irq, 1'b0);
    ctrl(3'h0, 1'b0, 1'b1, 1'b0, 1'b0);
    wait_bit(acp_pkg::STAT_REF_READY, 1'b1);
    rdc(acp_pkg::OFS_IRQ_ST, 32'h0000_0006);
    ctrl(3'h0, 1'b0, 1'b1, 1'b0, 1'b1);
    wr(acp_pkg::OFS_START, 32'h0000_0001);
    wait_bit(acp_pkg::STAT_ACTIVE, 1'b0);
    rdc(acp_pkg::OFS_STATUS, 32'h0000_000C);
    rdc(acp_pkg::OFS_IRQ_ST, 32'h0000_0004);
    ctrl(3'h0, 1'b0, 1'b1, 1'b0, 1'b0);
    repeat (acp_pkg::NAP_WAKE_CYC + 4) @(posedge clock_i);
    conv(3'h0, 1'b0, 12'h7D2, 12'h7D2);
    rdc(8'h40, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    wr(acp_pkg::OFS_RESULT, 32'h0000_0000);
    rdc(acp_pkg::OFS_RESULT, 32'h0000_07D2);
    rdc(acp_pkg::OFS_CTRL, 32'h0000_0010);
    check(hresp, 1'b0);
    check(done_cnt, n_conv);
    final_report();
  end
endmodule
